// ==== irt_defines.svh ====
// Constants for the register-port I2C target
`ifndef IRT_DEFINES_SVH
`define IRT_DEFINES_SVH
`define IRT_TARGET_ADDR 7'h6c
`define IRT_UNMAPPED_DATA 8'hff
`define IRT_REG_TOP 8'h44
`define IRT_ADDR_W 8
`define IRT_DATA_W 8
`define IRT_SYNC_STAGES 2
`endif

// ==== irt_host_model.sv ====
// Behavioural I2C controller driving the target at fast-plus rate
`timescale 1ns/10ps
module irt_host_model (
  input wire logic lclk, // Link tick, 15 ns
  input wire logic scl, // Resolved SCL
  input wire logic sda, // Resolved SDA
  output logic scl_h, // SCL release, 1 = released
  output logic sda_h // SDA release, 1 = released
);
  localparam int Q = 17; // Ticks per quarter bit, under 1 Mbit/s
  localparam int TBUF = 8000; // 120 us spacing before START
  int to_cnt = 0; // Stretch waits that ran out
  initial begin
    scl_h = 1'b1; // Idle bus released
    sda_h = 1'b1;
  end
  task automatic q(input int n);
    repeat (n * Q) @(posedge lclk);
  endtask
  // Raise SCL and wait out a stretch, bounded
  task automatic hi();
    int k;
    scl_h <= 1'b1;
    k = 0;
    while (!scl && k < 2000) begin
      @(posedge lclk);
      k++;
    end
    if (k == 2000) to_cnt++;
    q(1);
  endtask
  // One bit: SDA moves only with SCL low
  task automatic bit_x(input logic b, output logic r);
    sda_h <= b;
    q(1);
    hi();
    r = sda;
    q(1);
    scl_h <= 1'b0;
    q(1);
  endtask
  // START or repeated START after the spacing gap
  task automatic start();
    sda_h <= 1'b1;
    q(1);
    hi();
    repeat (TBUF) @(posedge lclk);
    sda_h <= 1'b0;
    q(1);
    scl_h <= 1'b0;
    q(1);
  endtask
  task automatic stop();
    sda_h <= 1'b0;
    q(1);
    hi();
    sda_h <= 1'b1;
    q(1);
  endtask
  task automatic wr(input logic [7:0] b, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_x(b[i], r); // MSB first
    bit_x(1'b1, r); // Released for the ninth pulse
    ack = !r;
  endtask
  task automatic rd(input logic ack, output logic [7:0] b);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_x(1'b1, r);
      b[i] = r;
    end
    bit_x(!ack, r); // NACK on the last byte
  endtask
endmodule

// ==== irt_i2c_target.sv ====
// I2C register target, oversampling SCL and SDA on ref_clk
//
// Contract
// - Answer only target address 0x6C
// - Reads outside the map return 0xFF
// - Undefined register address: NACK, then idle
// - Runs at standard, fast, fast-plus rates
// - SDA changes only while SCL low
// - Detect START and STOP conditions
// - Bus busy from START until STOP
// - Idle bus: both lines released high
// - Eight bits MSB first plus ACK, unlimited
// - Target may stretch SCL between bytes
// - Receiver pulls SDA low on ninth pulse
// - Eighth bit is direction, 1 means read
// - Write: address, register, data, store
// - Multi-byte access crosses register bounds
`timescale 1ns/10ps
`include "irt_defines.svh"
module irt_i2c_target #(
  parameter int REG_TOP = `IRT_REG_TOP
) (
  input wire logic ref_clk, // 25 MHz system clock
  input wire logic rst_n, // Async reset, active low
  input wire logic scl_i, // SCL pin level
  output logic scl_o, // SCL drive value, always low
  output logic scl_oe_n, // SCL drive enable, active low
  input wire logic sda_i, // SDA pin level
  output logic sda_o, // SDA drive value, always low
  output logic sda_oe_n, // SDA drive enable, active low
  output logic bus_busy, // High between START and STOP
  output logic [7:0] reg_addr, // Register address to storage
  output logic [7:0] reg_wdata, // Write data to storage
  output logic reg_wr, // One-cycle write strobe
  output logic reg_rd, // One-cycle read strobe
  input wire logic [7:0] reg_rdata, // Read data, valid with reg_rdy
  input wire logic reg_rdy // Storage ready; low stretches SCL while a read byte is pending
);
  // Pointer is eight bits: a top above 255 cannot be served
  if (REG_TOP > 255 || REG_TOP < 0) begin
    $error("REG_TOP out of range");
  end

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers; 40 ns sampling leaves margin at 1 Mbit/s
  // Two stages cost about two cycles of latency on every edge
  logic [1:0] pins_s;
  irt_sync #(.WIDTH(2)) u_sync (
    .clk(ref_clk),
    .rst_n(rst_n),
    .d_in({scl_i, sda_i}),
    .d_out(pins_s)
  );

  logic scl_d_reg, sda_d_reg;
  logic scl_d_next, sda_d_next;
  logic scl_rise, scl_fall, start_det, stop_det;
  // Edge and condition decode on synchronised lines
  always_comb begin
    scl_d_next = pins_s[1];
    sda_d_next = pins_s[0];
    scl_rise = pins_s[1] & ~scl_d_reg;
    scl_fall = ~pins_s[1] & scl_d_reg;
    start_det = pins_s[1] & scl_d_reg & sda_d_reg & ~pins_s[0];
    stop_det = pins_s[1] & scl_d_reg & ~sda_d_reg & pins_s[0];
  end
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      scl_d_reg <= 1'b1;
      sda_d_reg <= 1'b1;
    end else begin
      scl_d_reg <= scl_d_next;
      sda_d_reg <= sda_d_next;
    end
  end

  // Map has no holes: every pointer up to REG_TOP is defined
  function automatic logic reg_defined(input logic [7:0] a);
    reg_defined = (int'(a) <= REG_TOP);
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Protocol state
  irt_pkg::irt_state_e st_reg, st_next;
  logic [7:0] sh_reg, sh_next;
  logic [3:0] cnt_reg, cnt_next;
  logic rw_reg, rw_next;
  logic ptr_ok_reg, ptr_ok_next; // Pointer byte already taken
  logic ack_reg, ack_next; // Drive ACK on ninth bit
  logic sda_oe_n_reg, sda_oe_n_next;
  logic scl_oe_n_reg, scl_oe_n_next;
  logic busy_reg, busy_next;
  logic [7:0] addr_reg, addr_next;
  logic [7:0] wdata_reg, wdata_next;
  logic wr_reg, wr_next, rd_reg, rd_next;
  logic load_pend_reg, load_pend_next; // Waiting for read data

  // Next-state logic for the byte engine
  always_comb begin
    st_next = st_reg;
    sh_next = sh_reg;
    cnt_next = cnt_reg;
    rw_next = rw_reg;
    ptr_ok_next = ptr_ok_reg;
    ack_next = ack_reg;
    sda_oe_n_next = sda_oe_n_reg;
    scl_oe_n_next = scl_oe_n_reg;
    busy_next = busy_reg;
    addr_next = addr_reg;
    wdata_next = wdata_reg;
    wr_next = 1'b0;
    rd_next = 1'b0;
    load_pend_next = load_pend_reg;
    // START and STOP win over any bit in flight, so cut frames end
    if (start_det) begin
      busy_next = 1'b1;
      st_next = irt_pkg::IRT_ADDR;
      cnt_next = 4'h0;
      sda_oe_n_next = 1'b1;
      scl_oe_n_next = 1'b1;
      load_pend_next = 1'b0;
    end else if (stop_det) begin
      busy_next = 1'b0;
      st_next = irt_pkg::IRT_IDLE;
      sda_oe_n_next = 1'b1;
      scl_oe_n_next = 1'b1;
      // Pointer survives a repeated START, cleared only at STOP
      ptr_ok_next = 1'b0;
      load_pend_next = 1'b0;
    end else begin
      case (st_reg)
        irt_pkg::IRT_IDLE: begin
          sda_oe_n_next = 1'b1;
          scl_oe_n_next = 1'b1;
        end
        irt_pkg::IRT_ADDR, irt_pkg::IRT_RXB: begin
          if (scl_rise) begin
            sh_next = {sh_reg[6:0], pins_s[0]};
            cnt_next = cnt_reg + 4'h1;
          end
          if (scl_fall && cnt_reg == 4'h8) begin
            cnt_next = 4'h0;
            if (st_reg == irt_pkg::IRT_ADDR) begin
              if (sh_reg[7:1] == `IRT_TARGET_ADDR) begin
                rw_next = sh_reg[0];
                ack_next = 1'b1;
                // Read: fetch the first byte while the ACK bit runs
                if (sh_reg[0]) begin
                  rd_next = 1'b1;
                  load_pend_next = 1'b1;
                end
              end else begin
                ack_next = 1'b0;
              end
              st_next = irt_pkg::IRT_AACK;
            end else begin
              // First byte after a write address is the pointer unless one was taken since STOP
              if (!ptr_ok_reg) begin
                addr_next = sh_reg;
                ack_next = reg_defined(sh_reg);
                ptr_ok_next = reg_defined(sh_reg);
              end else begin
                wdata_next = sh_reg;
                wr_next = 1'b1;
                ack_next = 1'b1;
              end
              st_next = irt_pkg::IRT_RACK;
            end
            sda_oe_n_next = ~ack_next;
          end
        end
        irt_pkg::IRT_AACK, irt_pkg::IRT_RACK: begin
          if (scl_fall) begin
            sda_oe_n_next = 1'b1;
            if (!ack_reg) begin
              // Refused byte: ignore the rest until START; still busy
              st_next = irt_pkg::IRT_IDLE;
            end else if (st_reg == irt_pkg::IRT_AACK && rw_reg) begin
              st_next = irt_pkg::IRT_TXB;
              scl_oe_n_next = ~load_pend_reg;
              sda_oe_n_next = load_pend_reg ? 1'b1 : sh_reg[7];
            end else begin
              // Write address or byte accepted: take the next byte
              st_next = irt_pkg::IRT_RXB;
            end
          end
          if (st_reg == irt_pkg::IRT_RACK && wr_reg) begin
            addr_next = addr_reg + 8'h01;
          end
        end
        irt_pkg::IRT_TXB: begin
          if (load_pend_reg && reg_rdy) begin
            sh_next = reg_defined(addr_reg) ? reg_rdata
                                            : `IRT_UNMAPPED_DATA;
            addr_next = addr_reg + 8'h01;
            load_pend_next = 1'b0;
            sda_oe_n_next = reg_defined(addr_reg) ? reg_rdata[7]
                                                  : 1'b1;
            // SCL stays held one more cycle so the MSB settles first
            cnt_next = 4'h0;
          end else if (!load_pend_reg) begin
            scl_oe_n_next = 1'b1;
            if (scl_rise) begin
              cnt_next = cnt_reg + 4'h1;
            end
            // Next bit leaves just after SCL falls, long before it rises
            if (scl_fall) begin
              if (cnt_reg == 4'h8) begin
                sda_oe_n_next = 1'b1;
                st_next = irt_pkg::IRT_TACK;
                cnt_next = 4'h0;
              end else begin
                sh_next = {sh_reg[6:0], 1'b1};
                sda_oe_n_next = sh_reg[6];
              end
            end
          end
        end
        irt_pkg::IRT_TACK: begin
          if (scl_rise) begin
            ack_next = ~pins_s[0];
          end
          if (scl_fall) begin
            // Host wants more: stretch while the next byte comes
            if (ack_reg) begin
              rd_next = 1'b1;
              load_pend_next = 1'b1;
              st_next = irt_pkg::IRT_TXB;
              scl_oe_n_next = 1'b0;
            end else begin
              st_next = irt_pkg::IRT_IDLE;
            end
          end
        end
        default: begin
          st_next = irt_pkg::IRT_IDLE;
        end
      endcase
    end
  end

  // Registers of the byte engine
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_reg <= irt_pkg::IRT_IDLE;
      sh_reg <= 8'h00;
      cnt_reg <= 4'h0;
      rw_reg <= 1'b0;
      ptr_ok_reg <= 1'b0;
      ack_reg <= 1'b0;
      sda_oe_n_reg <= 1'b1;
      scl_oe_n_reg <= 1'b1;
      busy_reg <= 1'b0;
      addr_reg <= 8'h00;
      wdata_reg <= 8'h00;
      wr_reg <= 1'b0;
      rd_reg <= 1'b0;
      load_pend_reg <= 1'b0;
    end else begin
      st_reg <= st_next;
      sh_reg <= sh_next;
      cnt_reg <= cnt_next;
      rw_reg <= rw_next;
      ptr_ok_reg <= ptr_ok_next;
      ack_reg <= ack_next;
      sda_oe_n_reg <= sda_oe_n_next;
      scl_oe_n_reg <= scl_oe_n_next;
      busy_reg <= busy_next;
      addr_reg <= addr_next;
      wdata_reg <= wdata_next;
      wr_reg <= wr_next;
      rd_reg <= rd_next;
      load_pend_reg <= load_pend_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs, open drain: value is low, enable active low
  // Constant low kept in a flop so every output is registered
  logic zero_reg;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      zero_reg <= 1'b0;
    end else begin
      zero_reg <= 1'b0;
    end
  end
  assign scl_o = zero_reg;
  assign sda_o = zero_reg;
  assign scl_oe_n = scl_oe_n_reg;
  assign sda_oe_n = sda_oe_n_reg;
  assign bus_busy = busy_reg;
  assign reg_addr = addr_reg;
  assign reg_wdata = wdata_reg;
  assign reg_wr = wr_reg;
  assign reg_rd = rd_reg;
endmodule

// ==== irt_i2c_target_bench.sv ====
// Self-checking bench for the I2C register target
`timescale 1ns/10ps
module irt_i2c_target_bench;
  localparam logic [7:0] TOP = 8'h44; // Highest defined register
  logic ref_clk = 1'b0;
  logic lclk = 1'b0;
  logic rst_n = 1'b0;
  logic reg_rdy = 1'b0;
  logic [7:0] reg_rdata = 8'h00;
  logic scl_oe_n, sda_oe_n, scl_h, sda_h, bus_busy, reg_wr, reg_rd;
  logic scl_o, sda_o;
  int n_acc = 0; // Register strobes seen so far
  logic [7:0] reg_addr, reg_wdata;
  logic [7:0] mem [256];
  logic [7:0] mdl [256];
  logic [31:0] seed = 32'h80e3_5837;
  int n_errors = 0;
  int check_count = 0;
  wire scl = scl_h & (scl_oe_n | scl_o); // Wired AND with pull-up
  wire sda = sda_h & (sda_oe_n | sda_o);
  always #20 ref_clk = ~ref_clk;
  always #7.5 lclk = ~lclk;
  irt_i2c_target i_irt_i2c_target (.ref_clk(ref_clk), .rst_n(rst_n),
    .scl_i(scl), .scl_o(scl_o), .scl_oe_n(scl_oe_n), .sda_i(sda),
    .sda_o(sda_o), .sda_oe_n(sda_oe_n), .bus_busy(bus_busy),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rdy(reg_rdy));
  irt_host_model i_irt_host_model (.lclk(lclk), .scl(scl), .sda(sda),
    .scl_h(scl_h), .sda_h(sda_h));
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // Register storage with random ready, off the sampling edge
  always @(negedge ref_clk) begin
    if (reg_wr) mem[reg_addr] = reg_wdata;
    if (reg_rd) reg_rdata <= mem[reg_addr];
    if (reg_wr || reg_rd) n_acc++;
    reg_rdy <= seed[3];
    void'(rnd());
  end
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    check_count++;
    if (g !== e) begin
      n_errors++;
      $display("[FAIL] t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  // Whole transfer: pointer, then write or restart and read
  task automatic xfer(input logic [6:0] dev, input logic [7:0] a,
      input int n, input bit rd);
    logic k;
    logic [7:0] b;
    int acc0;
    acc0 = n_acc;
    i_irt_host_model.start();
    chk({7'h0, bus_busy}, 8'h01);
    i_irt_host_model.wr({dev, 1'b0}, k);
    chk({7'h0, k}, {7'h0, dev == 7'h6c});
    if (k) i_irt_host_model.wr(a, k);
    if (dev == 7'h6c) chk({7'h0, k}, {7'h0, a <= TOP});
    for (int i = 0; k && !rd && i < n; i++) begin
      b = 8'(rnd());
      mdl[a + i] = b;
      i_irt_host_model.wr(b, k);
      chk({7'h0, k}, 8'h01);
    end
    if (k && rd) begin
      i_irt_host_model.start();
      i_irt_host_model.wr({dev, 1'b1}, k);
      chk({7'h0, k}, 8'h01);
      for (int i = 0; i < n; i++) begin
        i_irt_host_model.rd(i < n - 1, b);
        chk(b, (a + i > TOP) ? 8'hff : mdl[a + i]);
      end
    end
    i_irt_host_model.stop();
    repeat (8) @(negedge ref_clk);
    chk({7'h0, bus_busy}, 8'h00);
    chk(8'(n_acc - acc0), (dev == 7'h6c && a <= TOP) ? 8'(n) : 8'h00);
  endtask
  task automatic results();
    n_errors += i_irt_host_model.to_cnt;
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    repeat (90000) @(posedge ref_clk);
    n_errors++;
    results();
  end
  initial begin
    logic [7:0] p;
    for (int i = 0; i < 256; i++) begin
      mem[i] = 8'(rnd());
      mdl[i] = mem[i];
    end
    repeat (3) @(negedge ref_clk);
    rst_n <= 1'b1;
    repeat (4) @(negedge ref_clk);
    for (int j = 0; j < 3; j++) begin
      p = 8'(rnd()) % 8'h42;
      xfer(7'h6c, p, 3, 1'b0);
      xfer(7'h6c, p, 3, 1'b1);
    end
    xfer(7'h6c, 8'h43, 3, 1'b1);
    xfer(7'h6c, 8'h45, 1, 1'b0);
    xfer(7'h6d, 8'h00, 1, 1'b0);
    results();
  end
endmodule

// ==== irt_i2c_target_properties.sv ====
// Port assertions for the I2C register target
`timescale 1ns/10ps
module irt_i2c_target_properties (
  input wire logic ref_clk, // Clock
  input wire logic rst_n, // Reset
  input wire logic scl_i, // SCL level
  input wire logic scl_o, // SCL value
  input wire logic scl_oe_n, // SCL enable
  input wire logic sda_o, // SDA value
  input wire logic sda_oe_n, // SDA enable
  input wire logic bus_busy, // Busy flag
  input wire logic [7:0] reg_addr, // Pointer
  input wire logic reg_wr, // Write strobe
  input wire logic reg_rd, // Read strobe
  input wire logic reg_rdy // Storage ready
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  ////////////////////////////////////////////////////////////////////////
  // Strobes, pointer and line drive
  a_wr_pulse: assert property (reg_wr |=> !reg_wr)
    else $error("write strobe too long");
  a_rd_pulse: assert property (reg_rd |=> !reg_rd)
    else $error("read strobe too long");
  a_wr_busy: assert property (reg_wr |-> bus_busy)
    else $error("write outside a transfer");
  a_rd_busy: assert property (reg_rd |-> bus_busy)
    else $error("read outside a transfer");
  a_ptr_step: assert property (
    reg_wr |=> reg_addr == $past(reg_addr) + 8'h01)
    else $error("pointer did not step");
  a_idle_release: assert property (!bus_busy |-> sda_oe_n && scl_oe_n)
    else $error("line driven on idle bus");
  a_stretch_end: assert property (
    !scl_oe_n && reg_rdy |-> ##[1:4] scl_oe_n)
    else $error("stretch held after ready");
  a_sda_scl_low: assert property ($changed(sda_oe_n) |-> !scl_i)
    else $error("SDA moved while SCL high");
  a_drive_low: assert property (!scl_o && !sda_o)
    else $error("open-drain value not low");
endmodule
bind irt_i2c_target irt_i2c_target_properties i_props (
  .ref_clk(ref_clk), .rst_n(rst_n), .scl_i(scl_i), .scl_o(scl_o),
  .scl_oe_n(scl_oe_n), .sda_o(sda_o), .sda_oe_n(sda_oe_n),
  .bus_busy(bus_busy), .reg_addr(reg_addr), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdy(reg_rdy));

// ==== irt_pkg.sv ====
// Types for the register-port I2C target
package irt_pkg;
  typedef enum logic [6:0] {
    IRT_IDLE = 7'b000_0001,
    IRT_ADDR = 7'b000_0010,
    IRT_AACK = 7'b000_0100,
    IRT_RXB  = 7'b000_1000,
    IRT_RACK = 7'b001_0000,
    IRT_TXB  = 7'b010_0000,
    IRT_TACK = 7'b100_0000
  } irt_state_e;
endpackage

// ==== irt_sync.sv ====
// Two-stage level synchroniser
`timescale 1ns/10ps
module irt_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk, // Destination clock
  input wire logic rst_n, // Async reset, active low
  input wire logic [WIDTH-1:0] d_in, // Foreign level
  output logic [WIDTH-1:0] d_out // Synchronised level
);
  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] out_reg;
  // Two flops, the first read only by the second
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      // Idle high level of open-drain lines, so no false edge on fill
      meta_reg <= '1;
      out_reg <= '1;
    end else begin
      meta_reg <= d_in;
      out_reg <= meta_reg;
    end
  end
  assign d_out = out_reg;
endmodule
